//--- msd_cfg.svh
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH

// Address space shape: 256 segments of 64 KB, four 16 KB pages each
`define MSD_SEG_COUNT    256
`define MSD_PAGE_BITS    14

// Flash interface register space and the trapping hole below it
`define MSD_FIFR_LO      24'hFF_FF00
`define MSD_TRAP_LO      24'hF0_0000
// Emulated program RAM and its mirror window
`define MSD_EPRAM_MIR_LO 24'hE9_0000
`define MSD_EPRAM_LO     24'hE8_0000
`define MSD_EPRAM_SEG    8'hE8
// Program RAM and its mirror window
`define MSD_PRAM_MIR_LO  24'hE1_0000
`define MSD_PRAM_LO      24'hE0_0000
`define MSD_PRAM_SEG     8'hE0
// Reserved program memory, flash array and its private sector
`define MSD_PMEM_RES_LO  24'hCC_0000
`define MSD_FLASH_LO     24'hC0_0000
`define MSD_FLASH_RSV_LO 24'hC0_F000
`define MSD_FLASH_RSV_HI 24'hC0_FFFF
// External memory above the IO area
`define MSD_EXT_HI_LO    24'h40_0000
// External IO area and local peripheral bus ranges
`define MSD_EXT_IO_LO    24'h20_5800
`define MSD_SER_LO       24'h20_4000
`define MSD_CAN_LO       24'h20_0000
// External memory below the local bus
`define MSD_EXT_MID_LO   24'h01_0000
// System segment areas
`define MSD_SFR_LO       24'h00_FE00
`define MSD_DUAL_PORT_RAM_LO     24'h00_F600
`define MSD_DUAL_PORT_RAM_BIT_LO 24'h00_FD00
`define MSD_DUAL_PORT_RAM_RES_LO 24'h00_F200
`define MSD_EXTENDED_REGISTER_AREA_HI      24'h00_F1FF
`define MSD_EXTENDED_REGISTER_AREA_LO      24'h00_F000
`define MSD_STANDBY_RAM_LO     24'h00_EC00
`define MSD_AUXILIARY_REGISTER_AREA_LO      24'h00_E000
`define MSD_DRAM_LO      24'h00_A000
`define MSD_DRAM_RES_LO  24'h00_8000

// Flash read protection password ports
`define MSD_PWD_ADDR     24'hFF_FF00
`define MSD_LOCK_ADDR    24'hFF_FF02

`endif

//--- msd_pkg.sv
package msd_pkg;

  // Access target selected by the decoder
  typedef enum logic [3:0] {
    MSD_T_EXT   = 4'h0,
    MSD_T_LBUS  = 4'h1,
    MSD_T_EXTIO = 4'h2,
    MSD_T_FLASH = 4'h3,
    MSD_T_PRAM  = 4'h4,
    MSD_T_EPRAM = 4'h5,
    MSD_T_DRAM  = 4'h6,
    MSD_T_DUAL_PORT_RAM = 4'h7,
    MSD_T_SFR   = 4'h8,
    MSD_T_EXTENDED_REGISTER_AREA  = 4'h9,
    MSD_T_AUXILIARY_REGISTER_AREA  = 4'hA,
    MSD_T_STANDBY_RAM = 4'hB,
    MSD_T_FIFR  = 4'hC,
    MSD_T_TRAP  = 4'hD
  } msd_target_t;

  // Flash read protection unlock progress
  typedef enum logic [1:0] {
    MSD_LK_LOCKED = 2'b00,
    MSD_LK_HALF   = 2'b01,
    MSD_LK_OPEN   = 2'b10
  } msd_lock_t;

endpackage

//--- msd_region.sv
`include "msd_cfg.svh"

module msd_region (
  // Access address
  input  wire logic [23:0]         addr,
  // Decode result
  output msd_pkg::msd_target_t     target,
  output logic [1:0]               flash_mod,
  output logic                     bit_area,
  output logic                     rsv_sector
);
  import msd_pkg::*;

  // One target per address, searched from the top of the space down
  always_comb begin
    if (addr >= `MSD_FIFR_LO) begin
      target = MSD_T_FIFR;
    end else if (addr >= `MSD_TRAP_LO) begin
      target = MSD_T_TRAP;
    end else if (addr >= `MSD_EPRAM_LO) begin
      target = MSD_T_EPRAM;
    end else if (addr >= `MSD_PRAM_LO) begin
      target = MSD_T_PRAM;
    end else if (addr >= `MSD_PMEM_RES_LO) begin
      target = MSD_T_TRAP;
    end else if (addr >= `MSD_FLASH_LO) begin
      target = MSD_T_FLASH;
    end else if (addr >= `MSD_EXT_HI_LO) begin
      target = MSD_T_EXT;
    end else if (addr >= `MSD_EXT_IO_LO) begin
      target = MSD_T_EXTIO;
    end else if (addr >= `MSD_CAN_LO) begin
      target = MSD_T_LBUS;
    end else if (addr >= `MSD_EXT_MID_LO) begin
      target = MSD_T_EXT;
    end else if (addr >= `MSD_SFR_LO) begin
      target = MSD_T_SFR;
    end else if (addr >= `MSD_DUAL_PORT_RAM_LO) begin
      target = MSD_T_DUAL_PORT_RAM;
    end else if (addr >= `MSD_DUAL_PORT_RAM_RES_LO) begin
      target = MSD_T_TRAP;
    end else if (addr >= `MSD_EXTENDED_REGISTER_AREA_LO) begin
      target = MSD_T_EXTENDED_REGISTER_AREA;
    end else if (addr >= `MSD_STANDBY_RAM_LO) begin
      target = MSD_T_STANDBY_RAM;
    end else if (addr >= `MSD_AUXILIARY_REGISTER_AREA_LO) begin
      target = MSD_T_AUXILIARY_REGISTER_AREA;
    end else if (addr >= `MSD_DRAM_LO) begin
      target = MSD_T_DRAM;
    end else if (addr >= `MSD_DRAM_RES_LO) begin
      target = MSD_T_TRAP;
    end else begin
      target = MSD_T_EXT;
    end
  end

  // Flash module number from the 256 KB boundaries
  assign flash_mod  = addr[19:18];
  // Private control sector of flash module 0
  assign rsv_sector = (addr >= `MSD_FLASH_RSV_LO) && (addr <= `MSD_FLASH_RSV_HI);
  // Directly bit addressable areas in the system segment
  assign bit_area   = ((addr >= `MSD_DUAL_PORT_RAM_BIT_LO) && (addr < `MSD_SFR_LO))
                    || (target == MSD_T_SFR) || (target == MSD_T_EXTENDED_REGISTER_AREA);

endmodule

//--- msd_decoder.sv
`include "msd_cfg.svh"

module msd_decoder (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Fetch unit request
  input  wire logic                 fetch_req,
  input  wire logic [23:0]          fetch_addr,
  // Fetch unit answer
  output logic                      fetch_ack,
  output msd_pkg::msd_target_t      fetch_target,
  output logic                      fetch_trap,
  output logic                      fetch_sysbus,
  output logic [2:0]                fetch_flash_sel,
  output logic [15:0]               fetch_word,
  // Data unit request
  input  wire logic                 data_req,
  input  wire logic [23:0]          data_addr,
  input  wire logic                 data_we,
  input  wire logic                 data_word,
  input  wire logic                 data_gpr,
  input  wire logic [3:0]           data_gpr_num,
  input  wire logic [15:0]          context_ptr,
  input  wire logic [15:0]          data_wdata,
  // Data unit answer
  output logic                      data_ack,
  output logic                      data_stall,
  output msd_pkg::msd_target_t      data_target,
  output logic [23:0]               data_phys_addr,
  output logic [1:0]                data_byte_en,
  output logic                      data_wr_en,
  output logic                      data_trap,
  output logic                      data_sysbus,
  output logic                      data_ext_io,
  output logic                      data_bit_ok,
  output logic                      data_wp_hit,
  output logic [2:0]                data_flash_sel,
  // Flash read line for the fetch unit
  input  wire logic [127:0]         flash_line,
  input  wire logic [7:0]           flash_check,
  // Protection settings
  input  wire logic [7:0]           pram_prot_size,
  input  wire logic                 read_prot_en,
  input  wire logic [15:0]          pwd_first,
  input  wire logic [15:0]          pwd_second,
  // Protection status
  output logic                      flash_unlocked
);
  import msd_pkg::*;

  // Correct a single flipped bit of a flash line
  function automatic logic [127:0] msd_fix(input logic [127:0] d,
                                           input logic [7:0]   c);
    logic [7:0]   s;
    logic [127:0] r;
    s = c;
    r = d;
    for (int i = 0; i < 128; i++) begin
      if (d[i]) begin
        s = s ^ 8'(i + 1);
      end
    end
    if ((s != 8'h00) && (s <= 8'h80)) begin
      r[7'(s - 8'h01)] = ~r[7'(s - 8'h01)];
    end
    return r;
  endfunction

  // Decode results of both units
  msd_target_t   f_tgt;                 // Fetch target
  msd_target_t   d_tgt;                 // Data target
  logic [1:0]    f_mod;                 // Fetch flash module
  logic [1:0]    d_mod;                 // Data flash module
  logic          f_bit;                 // Fetch bit area (unused)
  logic          d_bit;                 // Data bit area
  logic          f_rsv;                 // Fetch hits private sector
  logic          d_rsv;                 // Data hits private sector
  logic [15:0]   gpr_off;               // Register offset in the bank
  logic [23:0]   d_eff;                 // Effective data address
  logic          d_stall;               // Same flash module conflict
  logic          d_take;                // Data request accepted now
  logic          d_misalign;            // Word at odd address
  logic          d_rd_locked;           // Read of a protected flash
  logic          d_wp;                  // Write into protected section
  logic          d_bad;                 // Data access traps
  logic [127:0]  fixed_line;            // Corrected flash line
  msd_lock_t     lock_q;                // Unlock progress

  // Register bank address: word Rn or byte RLn/RHn pairs
  always_comb begin
    if (data_word) begin
      gpr_off = {11'h000, data_gpr_num, 1'b0};
    end else begin
      gpr_off = {12'h000, data_gpr_num[3:1], data_gpr_num[0]};
    end
  end

  // Register accesses land in the system segment bank
  assign d_eff = data_gpr ? {8'h00, 16'(context_ptr + gpr_off)}
                          : data_addr;

  // Fetch side decoder
  msd_region u_fetch_region (
    .addr       (fetch_addr),
    .target     (f_tgt),
    .flash_mod  (f_mod),
    .bit_area   (f_bit),
    .rsv_sector (f_rsv)
  );

  // Data side decoder, independent so both run together
  msd_region u_data_region (
    .addr       (d_eff),
    .target     (d_tgt),
    .flash_mod  (d_mod),
    .bit_area   (d_bit),
    .rsv_sector (d_rsv)
  );

  // Data waits only when both units want the same flash module
  assign d_stall = data_req && fetch_req && (f_tgt == MSD_T_FLASH)
                && (d_tgt == MSD_T_FLASH) && (f_mod == d_mod);
  assign d_take  = data_req && !d_stall;

  // Word accesses must be even
  assign d_misalign = data_word && d_eff[0];
  // Protected flash reads before the password was given
  assign d_rd_locked = !data_we && (d_tgt == MSD_T_FLASH)
                    && read_prot_en && (lock_q != MSD_LK_OPEN);
  // Low part of program RAM below the programmed size is read only
  assign d_wp = data_we && (d_tgt == MSD_T_PRAM)
             && (d_eff[15:8] < pram_prot_size);
  // Data trap causes; flash array is programmed via its interface only
  assign d_bad = (d_tgt == MSD_T_TRAP) || d_rsv || d_misalign
              || d_rd_locked
              || (data_we && (d_tgt == MSD_T_FLASH));

  // Error corrected flash line for code fetches
  assign fixed_line = msd_fix(flash_line, flash_check);

  // Fetch unit answer, one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ack       <= 1'b0;
      fetch_target    <= MSD_T_EXT;
      fetch_trap      <= 1'b0;
      fetch_sysbus    <= 1'b0;
      fetch_flash_sel <= 3'h0;
      fetch_word      <= 16'h0000;
    end else begin
      fetch_ack <= fetch_req;
      if (fetch_req) begin
        fetch_target <= f_tgt;
        // Fetch traps on holes, the private sector and odd addresses
        fetch_trap   <= (f_tgt == MSD_T_TRAP) || f_rsv
                     || fetch_addr[0];
        // Code from external memory crosses the system bus
        fetch_sysbus <= (f_tgt == MSD_T_EXT) || (f_tgt == MSD_T_EXTIO)
                     || (f_tgt == MSD_T_LBUS);
        // One select per flash module
        if ((f_tgt == MSD_T_FLASH) && (f_mod != 2'h3)) begin
          fetch_flash_sel <= 3'(3'h1 << f_mod);
        end else begin
          fetch_flash_sel <= 3'h0;
        end
        // Word out of the 128-bit line
        fetch_word <= fixed_line[{fetch_addr[3:1], 4'h0} +: 16];
      end
    end
  end

  // Data unit answer, one cycle after an accepted request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_ack       <= 1'b0;
      data_stall     <= 1'b0;
      data_target    <= MSD_T_EXT;
      data_phys_addr <= 24'h00_0000;
      data_byte_en   <= 2'h0;
      data_wr_en     <= 1'b0;
      data_trap      <= 1'b0;
      data_sysbus    <= 1'b0;
      data_ext_io    <= 1'b0;
      data_bit_ok    <= 1'b0;
      data_wp_hit    <= 1'b0;
      data_flash_sel <= 3'h0;
    end else begin
      data_ack   <= d_take;
      data_stall <= d_stall;
      if (d_take) begin
        data_target <= d_tgt;
        // Mirror windows fold onto the real RAM
        if (d_tgt == MSD_T_PRAM) begin
          data_phys_addr <= {`MSD_PRAM_SEG, d_eff[15:0]};
        end else if (d_tgt == MSD_T_EPRAM) begin
          data_phys_addr <= {`MSD_EPRAM_SEG, d_eff[15:0]};
        end else begin
          data_phys_addr <= d_eff;
        end
        // Byte lanes: low byte at the even address
        if (data_word) begin
          data_byte_en <= 2'h3;
        end else begin
          data_byte_en <= d_eff[0] ? 2'h2 : 2'h1;
        end
        data_wr_en  <= data_we && !d_bad && !d_wp;
        data_wp_hit <= d_wp;
        data_trap   <= d_bad;
        // Program memory, external and local bus go over the system bus
        data_sysbus <= (d_tgt == MSD_T_FLASH) || (d_tgt == MSD_T_PRAM)
                    || (d_tgt == MSD_T_EPRAM) || (d_tgt == MSD_T_EXT)
                    || (d_tgt == MSD_T_LBUS)
                    || (d_tgt == MSD_T_EXTIO);
        // External IO accesses run without pipeline shortcuts
        data_ext_io <= (d_tgt == MSD_T_EXTIO);
        // Bit access: fixed areas, or any dual-port byte used as register
        data_bit_ok <= d_bit || (data_gpr
                    && (d_tgt == MSD_T_DUAL_PORT_RAM));
        if ((d_tgt == MSD_T_FLASH) && (d_mod != 2'h3)) begin
          data_flash_sel <= 3'(3'h1 << d_mod);
        end else begin
          data_flash_sel <= 3'h0;
        end
      end else begin
        data_wr_en  <= 1'b0;
        data_wp_hit <= 1'b0;
      end
    end
  end

  // Password sequence: two matching writes unlock, a lock write relocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= MSD_LK_LOCKED;
    end else if (d_take && data_we && (d_eff == `MSD_LOCK_ADDR)) begin
      lock_q <= MSD_LK_LOCKED;
    end else if (d_take && data_we && (d_eff == `MSD_PWD_ADDR)) begin
      unique case (lock_q)
        MSD_LK_LOCKED: begin
          lock_q <= (data_wdata == pwd_first) ? MSD_LK_HALF
                                              : MSD_LK_LOCKED;
        end
        MSD_LK_HALF: begin
          lock_q <= (data_wdata == pwd_second) ? MSD_LK_OPEN
                                               : MSD_LK_LOCKED;
        end
        MSD_LK_OPEN: begin
          lock_q <= MSD_LK_OPEN;
        end
        default: begin
          lock_q <= MSD_LK_LOCKED;
        end
      endcase
    end
  end

  // Unlock state shown to the outside
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_unlocked <= 1'b0;
    end else begin
      flash_unlocked <= (lock_q == MSD_LK_OPEN);
    end
  end

  // Checks on the decoder
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_fetch_ack_next: assert property (
    fetch_req |=> fetch_ack)
    else $error("fetch not answered");

  a_trap_hole: assert property (
    d_take && !data_gpr && (data_addr >= `MSD_TRAP_LO)
    && (data_addr < `MSD_FIFR_LO) |=> data_trap && !data_wr_en)
    else $error("reserved hole did not trap");

  a_odd_word: assert property (
    d_take && data_word && d_eff[0] |=> data_trap)
    else $error("odd word access not trapped");

  a_byte_lane: assert property (
    d_take && !data_word |=> $onehot(data_byte_en)
    && (data_byte_en[1] == data_phys_addr[0]))
    else $error("byte lane wrong");

  a_wp_block: assert property (
    d_take && data_we && (d_tgt == MSD_T_PRAM)
    && (d_eff[15:8] < pram_prot_size) |=> data_wp_hit && !data_wr_en)
    else $error("protected write passed");

  a_ext_io: assert property (
    d_take && (d_eff >= `MSD_EXT_IO_LO) && (d_eff < `MSD_EXT_HI_LO)
    |=> data_ext_io && data_sysbus)
    else $error("external IO flag missing");

  a_mirror_fold: assert property (
    d_take && (d_eff >= `MSD_PRAM_MIR_LO) && (d_eff < `MSD_EPRAM_LO)
    |=> data_phys_addr[23:16] == `MSD_PRAM_SEG)
    else $error("mirror not folded");

  a_flash_parallel: assert property (
    fetch_req && data_req && (f_tgt == MSD_T_FLASH)
    && (d_tgt == MSD_T_FLASH) && (f_mod != d_mod)
    |=> fetch_ack && data_ack && ((fetch_flash_sel & data_flash_sel) == 3'h0))
    else $error("flash modules not parallel");

  a_unlock_seq: assert property (
    $rose(flash_unlocked) |-> $past(data_we, 2) && $past(data_req, 2)
    && ($past(data_wdata, 2) == $past(pwd_second, 2)))
    else $error("unlock without password");

  a_locked_read: assert property (
    d_take && d_rd_locked |=> data_trap && !data_wr_en)
    else $error("locked flash read not trapped");

  c_both_units: cover property (fetch_ack && data_ack);
  c_stall: cover property (data_stall);
  c_unlock: cover property ($rose(flash_unlocked));
  c_wp_hit: cover property (data_wp_hit);

endmodule

//--- msd_cpu_model.sv
module msd_cpu_model (
  // Clock
  input  wire logic        clock,
  // Fetch requests
  output logic             fetch_req,
  output logic [23:0]      fetch_addr,
  // Data requests
  output logic             data_req,
  output logic [23:0]      data_addr,
  output logic             data_we,
  output logic             data_word,
  output logic             data_gpr,
  output logic [3:0]       data_gpr_num,
  output logic [15:0]      data_wdata,
  input  wire logic        data_ack,
  input  wire logic        data_stall
);
  timeunit 1ns;
  timeprecision 1ns;

  // Data accesses that never saw an acknowledge
  int timeouts = 0;

  // Idle levels from time zero
  initial begin
    {fetch_req, data_req, data_we, data_word, data_gpr} = 5'h00;
    {fetch_addr, data_addr} = 48'h0;
    {data_gpr_num, data_wdata} = 20'h0;
  end

  // One fetch cycle; the address is inverted once released
  task automatic fetch(input logic [23:0] a);
    @(posedge clock);
    #1 fetch_req = 1'b1;
    fetch_addr = a;
    @(posedge clock);
    #1 fetch_req = 1'b0;
    fetch_addr = ~a;
  endtask

  // One data access, held through refusals until acknowledged or 16 cycles pass
  // Only mapped places are written, never unused register words
  task automatic data(input logic [23:0] a, input logic [2:0] ctl, input logic [3:0] num,
                      input logic [15:0] wd, output int cyc, output int st);
    cyc = 0;
    st = 0;
    @(posedge clock);
    #1 data_req = 1'b1;
    {data_we, data_word, data_gpr} = ctl;
    data_addr = a;
    data_gpr_num = num;
    data_wdata = wd;
    do begin
      @(posedge clock);
      #1 cyc++;
      if (data_stall === 1'b1) st++;
    end while (data_ack !== 1'b1 && cyc < 16);
    if (data_ack !== 1'b1) timeouts++;
    // Released lines are inverted so stale values never look valid
    data_req = 1'b0;
    data_addr = ~a;
    data_wdata = ~wd;
  endtask
endmodule

//--- msd_decoder_tb.sv
module msd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import msd_pkg::*;

  // Bench-driven clock, reset and settings
  logic         clock, rst_n, read_prot_en;
  logic [15:0]  context_ptr, pwd_first, pwd_second, fetch_word, data_wdata;
  logic [127:0] flash_line;
  logic [7:0]   flash_check, pram_prot_size;
  // Requests and answers
  logic         fetch_req, data_req, data_we, data_word, data_gpr, fetch_ack, fetch_trap;
  logic         fetch_sysbus, data_ack, data_stall, data_wr_en, data_trap, data_sysbus;
  logic         data_ext_io, data_bit_ok, data_wp_hit, flash_unlocked;
  logic [23:0]  fetch_addr, data_addr, data_phys_addr;
  logic [3:0]   data_gpr_num;
  logic [2:0]   fetch_flash_sel, data_flash_sel;
  logic [1:0]   data_byte_en;
  msd_target_t  fetch_target, data_target;
  int           fails = 0, comparisons = 0, cyc, st;

  msd_cpu_model u_cpu (.clock, .fetch_req, .fetch_addr, .data_req, .data_addr, .data_we,
    .data_word, .data_gpr, .data_gpr_num, .data_wdata, .data_ack, .data_stall);

  msd_decoder u_dut (.clock, .rst_n, .fetch_req, .fetch_addr, .fetch_ack, .fetch_target,
    .fetch_trap, .fetch_sysbus, .fetch_flash_sel, .fetch_word, .data_req, .data_addr, .data_we,
    .data_word, .data_gpr, .data_gpr_num, .context_ptr, .data_wdata, .data_ack, .data_stall,
    .data_target, .data_phys_addr, .data_byte_en, .data_wr_en, .data_trap, .data_sysbus,
    .data_ext_io, .data_bit_ok, .data_wp_hit, .data_flash_sel, .flash_line, .flash_check,
    .pram_prot_size, .read_prot_en, .pwd_first, .pwd_second, .flash_unlocked);

  // Compare helpers: values, flags, targets
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk({23'h0, g}, {23'h0, e});
  endtask
  task automatic chk_t(input msd_target_t g, input msd_target_t e);
    chk({20'h0, g}, {20'h0, e});
  endtask

  // Check byte: XOR of (index+1) over set bits
  function automatic logic [7:0] ecc(input logic [127:0] d);
    ecc = 8'h00;
    for (int i = 0; i < 128; i++) begin
      if (d[i]) ecc ^= 8'(i + 1);
    end
  endfunction

  // Every area but program RAM and the 01_0000 external window decodes to its target with the right flags
  task automatic t_map();
    logic [23:0] a [20] = '{24'h00_0100, 24'h00_8000, 24'h00_A000, 24'h00_E000, 24'h00_EC00,
      24'h00_F000, 24'h00_F200, 24'h00_F600, 24'h00_FD00, 24'h00_FE00, 24'h20_0000, 24'h20_4000,
      24'h20_5800, 24'h3F_FFFE, 24'h40_0000, 24'hC8_0000, 24'hCC_0000, 24'hE8_0000,
      24'hF0_0000, 24'hFF_FF04};
    msd_target_t t [20] = '{MSD_T_EXT, MSD_T_TRAP, MSD_T_DRAM, MSD_T_AUXILIARY_REGISTER_AREA, MSD_T_STANDBY_RAM,
      MSD_T_EXTENDED_REGISTER_AREA, MSD_T_TRAP, MSD_T_DUAL_PORT_RAM, MSD_T_DUAL_PORT_RAM, MSD_T_SFR, MSD_T_LBUS, MSD_T_LBUS,
      MSD_T_EXTIO, MSD_T_EXTIO, MSD_T_EXT, MSD_T_FLASH, MSD_T_TRAP, MSD_T_EPRAM, MSD_T_TRAP,
      MSD_T_FIFR};
    for (int i = 0; i < 20; i++) begin
      u_cpu.data(a[i], 3'b010, 4'h0, 16'h0000, cyc, st);
      chk_t(data_target, t[i]);
      chk_b(data_trap, t[i] == MSD_T_TRAP);
      chk_b(data_ext_io, t[i] == MSD_T_EXTIO);
      chk_b(data_bit_ok, t[i] inside {MSD_T_SFR, MSD_T_EXTENDED_REGISTER_AREA} || a[i][15:8] == 8'hFD);
      if (!(t[i] inside {MSD_T_TRAP, MSD_T_FIFR})) begin
        chk_b(data_sysbus, t[i] inside {MSD_T_EXT, MSD_T_LBUS, MSD_T_EXTIO, MSD_T_FLASH,
          MSD_T_EPRAM});
      end
    end
  endtask

  // Flash fetch returns the corrected lane; private sector traps
  task automatic t_fetch();
    logic [127:0] clean = 128'h0123_4567_89AB_CDEF_F0E1_D2C3_B4A5_9687;
    flash_check = ecc(clean);
    flash_line = clean ^ (128'h1 << 20);
    u_cpu.fetch(24'hC4_0012);
    chk_b(fetch_ack, 1'b1);
    chk_t(fetch_target, MSD_T_FLASH);
    chk({21'h0, fetch_flash_sel}, 24'h2);
    chk({8'h0, fetch_word}, {8'h0, clean[31:16]});
    u_cpu.fetch(24'hC0_F000);
    chk_b(fetch_trap, 1'b1);
    u_cpu.fetch(24'h40_0000);
    chk_b(fetch_sysbus, 1'b1);
  endtask

  // Protected program RAM, mirrors and odd words
  task automatic t_write();
    u_cpu.data(24'hE0_0100, 3'b110, 4'h0, 16'h5A5A, cyc, st);
    chk_b(data_wp_hit, 1'b1);
    chk_b(data_wr_en, 1'b0);
    u_cpu.data(24'hE1_0200, 3'b110, 4'h0, 16'hA5A5, cyc, st);
    chk_b(data_wr_en, 1'b1);
    chk(data_phys_addr, 24'hE0_0200);
    u_cpu.data(24'hE9_0010, 3'b010, 4'h0, 16'h0000, cyc, st);
    chk(data_phys_addr, 24'hE8_0010);
    u_cpu.data(24'h00_A001, 3'b010, 4'h0, 16'h0000, cyc, st);
    chk_b(data_trap, 1'b1);
  endtask

  // Byte lanes and register-bank addressing
  task automatic t_bytes();
    u_cpu.data(24'h00_A003, 3'b100, 4'h0, 16'h0011, cyc, st);
    chk({22'h0, data_byte_en}, 24'h2);
    u_cpu.data(24'h00_A002, 3'b000, 4'h0, 16'h0000, cyc, st);
    chk({22'h0, data_byte_en}, 24'h1);
    u_cpu.data(24'h00_0000, 3'b011, 4'hF, 16'h0000, cyc, st);
    chk(data_phys_addr, 24'h00_F61E);
    chk({22'h0, data_byte_en}, 24'h3);
    u_cpu.data(24'h00_0000, 3'b001, 4'h5, 16'h0000, cyc, st);
    chk(data_phys_addr, 24'h00_F605);
    chk_b(data_bit_ok, 1'b1);
  endtask

  // Same flash module: fetch wins; different modules run together
  task automatic t_par();
    fork
      u_cpu.fetch(24'hC0_0000);
      u_cpu.data(24'hC0_0100, 3'b010, 4'h0, 16'h0000, cyc, st);
    join
    chk(24'(st), 24'h1);
    fork
      u_cpu.fetch(24'hC8_0000);
      u_cpu.data(24'hC4_0100, 3'b010, 4'h0, 16'h0000, cyc, st);
    join
    chk(24'(cyc), 24'h1);
    chk({21'h0, data_flash_sel}, 24'h2);
    chk({21'h0, fetch_flash_sel}, 24'h4);
  endtask

  // Read protection opens with the password pair and closes again
  task automatic t_lock();
    read_prot_en = 1'b1;
    u_cpu.data(24'hC4_0000, 3'b010, 4'h0, 16'h0000, cyc, st);
    chk_b(data_trap, 1'b1);
    u_cpu.data(24'hFF_FF00, 3'b110, 4'h0, pwd_first, cyc, st);
    u_cpu.data(24'hFF_FF00, 3'b110, 4'h0, pwd_second, cyc, st);
    @(posedge clock);
    #1 chk_b(flash_unlocked, 1'b1);
    u_cpu.data(24'hC4_0000, 3'b010, 4'h0, 16'h0000, cyc, st);
    chk_b(data_trap, 1'b0);
    u_cpu.data(24'hFF_FF02, 3'b110, 4'h0, 16'h0000, cyc, st);
    @(posedge clock);
    #1 chk_b(flash_unlocked, 1'b0);
  endtask

  // Verdict and end of run
  task automatic final_report();
    // A data access that never got its acknowledge is a mismatch
    fails += u_cpu.timeouts;
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    read_prot_en = 1'b0;
    context_ptr = 16'hF600;
    flash_line = '0;
    flash_check = 8'h00;
    pram_prot_size = 8'h02;
    pwd_first = 16'h1234;
    pwd_second = 16'hABCD;
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    t_map();
    t_fetch();
    t_write();
    t_bytes();
    t_par();
    t_lock();
    final_report();
  end

  // Watchdog against a hung handshake
  initial begin
    #2_000_000;
    fails++;
    final_report();
  end
endmodule
